// [hw/pct_consts.svh]
// Register offsets, field positions and reset values of the timer.
// Assumes byte addresses on an 8-bit address port, one word per register.
`ifndef PCT_CONSTS_SVH
`define PCT_CONSTS_SVH
`define PCT_A_CTRL   8'h00
`define PCT_A_STAT   8'h04
`define PCT_A_MASK   8'h08
`define PCT_A_DMAEN  8'h0c
`define PCT_A_PSC    8'h10
`define PCT_A_ARR    8'h14
`define PCT_A_CNT    8'h18
`define PCT_A_DT     8'h1c
`define PCT_A_CHM    8'h20
`define PCT_A_CCR0   8'h30
`define PCT_F_EN     0
`define PCT_F_MODE   1
`define PCT_F_OPM    3
`define PCT_F_FRZ    4
`define PCT_F_DOFF   5
`define PCT_F_SLV    6
`define PCT_F_ENC    8
`define PCT_F_HALL   9
`define PCT_F_MOE    10
`define PCT_S_UPD    0
`define PCT_S_TRG    5
`define PCT_RST_CTRL 11'h000
`define PCT_RST_PSC  16'h0000
`define PCT_RST_ARR  16'hffff
`define PCT_RST_DT   8'h00
`endif

// [hw/pct_pkg.sv]
// Types shared by the timer and its capture/compare channels.
// Assumes the constants header is included where offsets are needed.
package pct_pkg;
    // Counting direction scheme
    typedef enum logic [1:0] {cnt_up, cnt_down, cnt_center, cnt_spare} pct_cnt_type;
    // Channel function
    typedef enum logic [1:0] {chm_off, chm_capture, chm_toggle, chm_pwm} pct_chm_type;
    // Reaction to the trigger line
    typedef enum logic [1:0] {slv_off, slv_reset, slv_gate, slv_start} pct_slv_type;
endpackage

// [hw/pct_channel.sv]
// One capture/compare channel: capture, toggle on match or PWM.
// Assumes the counter value is registered and inputs are synchronous.
module pct_channel #(
    parameter int CNT_W = 16                   // Counter width
) (
    input  wire logic              clk_i,      // Clock
    input  wire logic              rst_b_i,    // Async reset, active low
    input  pct_pkg::pct_chm_type   mode_i,     // Channel function
    input  wire logic              fall_i,     // Capture on falling edge
    input  wire logic              in_i,       // Capture input level
    input  wire logic [CNT_W-1:0]  cnt_i,      // Counter value
    input  wire logic [CNT_W-1:0]  arr_i,      // Auto-reload value
    input  wire logic              wr_i,       // Software write of compare
    input  wire logic [CNT_W-1:0]  wdata_i,    // Compare value written
    output logic      [CNT_W-1:0]  ccr_o,      // Compare/capture value
    output logic                   out_o,      // Reference output
    output logic                   evt_o       // Capture or match pulse
);
    logic             in_q_r;                  // Previous input level
    logic             match_q_r;               // Previous match state
    logic [CNT_W-1:0] ccr_r;                   // Compare/capture register
    logic             out_r;                   // Output level
    logic             evt_r;                   // Event pulse

    // Edge and match detection
    wire edge_hit = fall_i ? (in_q_r & ~in_i) : (in_i & ~in_q_r);
    wire cap_hit  = (mode_i == pct_pkg::chm_capture) & edge_hit;
    wire match    = (cnt_i == ccr_r);
    wire cmp_hit  = match & ~match_q_r & (mode_i inside {pct_pkg::chm_toggle, pct_pkg::chm_pwm});
    // Counter never exceeds reload, so ccr above it gives full duty
    wire pwm_lvl  = (cnt_i < ccr_r);

    // Capture wins over a software write in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_q_r    <= 1'b0;
            match_q_r <= 1'b0;
            ccr_r     <= '0;
            evt_r     <= 1'b0;
        end else begin
            in_q_r    <= in_i;
            match_q_r <= match;
            evt_r     <= cap_hit | cmp_hit;
            if (cap_hit) begin
                ccr_r <= cnt_i;
            end else if (wr_i) begin
                ccr_r <= wdata_i;
            end
        end
    end

    // Output waveform per function
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_r <= 1'b0;
        end else begin
            unique case (mode_i)
                pct_pkg::chm_pwm:    out_r <= pwm_lvl;
                pct_pkg::chm_toggle: out_r <= out_r ^ cmp_hit;
                pct_pkg::chm_off:    out_r <= 1'b0;
                pct_pkg::chm_capture: out_r <= 1'b0;
            endcase
        end
    end

    assign ccr_o = ccr_r;
    assign out_o = out_r;
    assign evt_o = evt_r;

    pwm_full_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (mode_i == pct_pkg::chm_pwm) && (ccr_r > arr_i) && (cnt_i <= arr_i) |=> out_o)
        else $error("pwm duty not full with compare above reload");
    capture_val_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cap_hit |=> (ccr_o == $past(cnt_i)) && evt_o)
        else $error("capture lost value or flag");
endmodule

// [hw/pct_timer.sv]
// Prescaled 16-bit timer with four channels and complementary outputs.
// Assumes synchronous pins, one clock and a plain register port.
// Notes on behaviour
// - 16-bit counter: up, down or center
// - Prescaler divides by 1 to 65536
// - Four channels: capture, compare, PWM, one-pulse
// - PWM edge-aligned or center-aligned
// - Three phases over six output lines
// - Complementary pairs with programmable dead time
// - Duty cycle anywhere from 0 to 100 percent
// - Advanced variant keeps all general functions
// - Debug halt with freeze stops counter
// - Debug halt may force the six phase outputs off
// - Trigger link starts, gates or resets
// - Own DMA request lines per timer
// - Quadrature encoder counts up or down
// - Hall sensor inputs act as trigger
`include "pct_consts.svh"
module pct_timer #(
    parameter int CNT_W    = 16,           // Counter and prescaler width
    parameter int DT_W     = 8,            // Dead-time counter width
    parameter bit ADVANCED = 1'b1          // Complementary outputs present
) (
    input  wire logic        clk_i,        // Clock, 100 MHz
    input  wire logic        rst_b_i,      // Async reset, active low
    input  wire logic [7:0]  addr_i,       // Register byte address
    input  wire logic [31:0] wr_data_i,    // Write data
    input  wire logic        wr_i,         // Write strobe
    input  wire logic        rd_i,         // Read strobe
    output logic      [31:0] rd_data_o,    // Read data, next cycle
    input  wire logic [3:0]  ch_i,         // Channel inputs
    input  wire logic        trig_i,       // Inter-timer trigger in
    input  wire logic        dbg_halt_i,   // Processor halted in debug
    output logic      [3:0]  ch_o,         // Channel outputs
    output logic      [2:0]  pwm_o,        // Phase outputs, high side
    output logic      [2:0]  pwm_n_o,      // Phase outputs, low side
    output logic             trig_o,       // Update pulse to other timers
    output logic      [5:0]  dma_req_o,    // DMA request pulses
    output logic             irq_o         // Interrupt, level
);
    // Software-visible registers
    logic [10:0]      ctrl_r;              // Control bits
    logic [5:0]       stat_r;              // Sticky event flags
    logic [5:0]       mask_r;              // Interrupt mask
    logic [5:0]       dma_en_r;            // DMA request enables
    logic [CNT_W-1:0] psc_r;               // Prescaler divisor minus one
    logic [CNT_W-1:0] arr_r;               // Auto-reload value
    logic [CNT_W-1:0] cnt_r;               // Counter
    logic [DT_W-1:0]  dt_r;                // Dead time in clocks
    logic [15:0]      chm_r;               // Channel modes, 4 bits each
    // Internal state
    logic [CNT_W-1:0] psc_cnt_r;           // Prescaler counter
    logic             dir_dn_r;            // Center mode going down
    logic [1:0]       enc_q_r;             // Previous encoder phases
    logic             trg_q_r;             // Previous trigger level
    logic [31:0]      rd_data_r;           // Read data register
    logic             trig_r;              // Trigger out pulse
    logic [5:0]       dma_r;               // DMA pulses
    logic [3:0]       ch_evt;              // Channel events
    logic [3:0]       ch_ref;              // Channel reference levels
    logic [CNT_W-1:0] ccr [4];             // Channel compare values
    logic [CNT_W-1:0] cnt_nxt;             // Next counter value
    logic             dir_nxt;             // Next direction
    logic             upd;                 // Update event

    // Write decode
    wire wr_ctrl = wr_i & (addr_i == `PCT_A_CTRL);
    wire wr_mask = wr_i & (addr_i == `PCT_A_MASK);
    wire wr_dma  = wr_i & (addr_i == `PCT_A_DMAEN);
    wire wr_psc  = wr_i & (addr_i == `PCT_A_PSC);
    wire wr_arr  = wr_i & (addr_i == `PCT_A_ARR);
    wire wr_cnt  = wr_i & (addr_i == `PCT_A_CNT);
    wire wr_dt   = wr_i & (addr_i == `PCT_A_DT);
    wire wr_chm  = wr_i & (addr_i == `PCT_A_CHM);
    wire rd_stat = rd_i & (addr_i == `PCT_A_STAT);

    // Control fields
    wire en       = ctrl_r[`PCT_F_EN];
    wire opm      = ctrl_r[`PCT_F_OPM];
    wire frz      = ctrl_r[`PCT_F_FRZ];
    wire doff     = ctrl_r[`PCT_F_DOFF];
    wire enc_mode = ctrl_r[`PCT_F_ENC];
    wire hall     = ctrl_r[`PCT_F_HALL];
    wire moe      = ctrl_r[`PCT_F_MOE];
    pct_pkg::pct_cnt_type cmode;           // Counting scheme
    pct_pkg::pct_slv_type smode;           // Trigger reaction
    assign cmode = pct_pkg::pct_cnt_type'(ctrl_r[`PCT_F_MODE +: 2]);
    assign smode = pct_pkg::pct_slv_type'(ctrl_r[`PCT_F_SLV +: 2]);

    // Hall sensors fold into one level; any sensor change toggles it
    wire hall_x  = ^ch_i[2:0];
    wire trg_lvl = hall ? hall_x : trig_i;
    wire trg_rise = trg_lvl & ~trg_q_r;

    // Quadrature decode, four counts per encoder cycle
    wire enc_step = (ch_i[0] ^ enc_q_r[0]) | (ch_i[1] ^ enc_q_r[1]);
    wire enc_up   = ch_i[0] ^ enc_q_r[1];

    // Run and tick; freeze only while the processor is halted
    wire frozen = dbg_halt_i & frz;
    wire run    = en & ~frozen & ((smode != pct_pkg::slv_gate) | trg_lvl);
    wire psc_hit = (psc_cnt_r == psc_r);
    wire tick   = run & (enc_mode ? enc_step : psc_hit);
    wire slv_rst = trg_rise & ~frozen & (smode == pct_pkg::slv_reset);
    wire slv_go  = trg_rise & (smode == pct_pkg::slv_start);
    wire up_now = enc_mode ? enc_up : (cmode == pct_pkg::cnt_up) |
                  ((cmode == pct_pkg::cnt_center) & ~dir_dn_r);
    wire center = ~enc_mode & (cmode == pct_pkg::cnt_center);
    wire at_top = (cnt_r == arr_r);
    wire at_bot = (cnt_r == '0);

    // Next counter value; software write beats trigger reset beats tick
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_dn_r;
        upd     = 1'b0;
        if (wr_cnt) begin
            cnt_nxt = wr_data_i[CNT_W-1:0];
        end else if (slv_rst) begin
            cnt_nxt = '0;
            dir_nxt = 1'b0;
            upd     = 1'b1;
        end else if (tick) begin
            if (up_now && at_top) begin
                // Center mode turns around instead of wrapping
                cnt_nxt = center ? cnt_r - 1'b1 : '0;
                dir_nxt = center;
                upd     = 1'b1;
            end else if (!up_now && at_bot) begin
                cnt_nxt = center ? cnt_r + 1'b1 : arr_r;
                dir_nxt = 1'b0;
                upd     = 1'b1;
            end else begin
                cnt_nxt = up_now ? cnt_r + 1'b1 : cnt_r - 1'b1;
            end
        end
    end

    // Events: update, four channels, trigger
    wire [5:0] ev = {trg_rise & (smode != pct_pkg::slv_off), ch_evt, upd};

    // Counter, prescaler and edge history
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r     <= '0;
            dir_dn_r  <= 1'b0;
            psc_cnt_r <= '0;
            enc_q_r   <= 2'h0;
            trg_q_r   <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            dir_dn_r <= dir_nxt;
            enc_q_r  <= ch_i[1:0];
            trg_q_r  <= trg_lvl;
            // Prescaler restarts with the counter so phase stays known
            if (slv_rst || wr_psc) begin
                psc_cnt_r <= '0;
            end else if (run) begin
                psc_cnt_r <= psc_hit ? '0 : psc_cnt_r + 1'b1;
            end
        end
    end

    // Control register; one-pulse clears enable, trigger start sets it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= `PCT_RST_CTRL;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wr_data_i[10:0];
            end
            if (upd && opm && !wr_ctrl) begin
                ctrl_r[`PCT_F_EN] <= 1'b0;
            end else if (slv_go) begin
                ctrl_r[`PCT_F_EN] <= 1'b1;
            end
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_r   <= 6'h00;
            dma_en_r <= 6'h00;
            psc_r    <= `PCT_RST_PSC;
            arr_r    <= `PCT_RST_ARR;
            dt_r     <= `PCT_RST_DT;
            chm_r    <= 16'h0000;
        end else begin
            if (wr_mask) mask_r <= wr_data_i[5:0];
            if (wr_dma) dma_en_r <= wr_data_i[5:0];
            if (wr_psc) psc_r <= wr_data_i[CNT_W-1:0];
            if (wr_arr) arr_r <= wr_data_i[CNT_W-1:0];
            if (wr_dt) dt_r <= wr_data_i[DT_W-1:0];
            if (wr_chm) chm_r <= wr_data_i[15:0];
        end
    end

    // Sticky flags: a new event beats the clear of a read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_r <= 6'h00;
            dma_r  <= 6'h00;
            trig_r <= 1'b0;
        end else begin
            stat_r <= (rd_stat ? 6'h00 : stat_r) | ev;
            dma_r  <= ev & dma_en_r;
            trig_r <= upd;
        end
    end

    // Channels; channel 0 sees the hall level in hall mode
    for (genvar k = 0; k < 4; k++) begin : g_ch
        wire ccr_wr = wr_i & (addr_i == `PCT_A_CCR0 + 8'(4 * k));
        wire ch_in  = (k == 0 && hall) ? hall_x : ch_i[k];
        pct_channel #(.CNT_W(CNT_W)) u_ch (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .mode_i  (pct_pkg::pct_chm_type'(chm_r[4*k +: 2])),
            .fall_i  (chm_r[4*k+2]),
            .in_i    (ch_in),
            .cnt_i   (cnt_r),
            .arr_i   (arr_r),
            .wr_i    (ccr_wr),
            .wdata_i (wr_data_i[CNT_W-1:0]),
            .ccr_o   (ccr[k]),
            .out_o   (ch_ref[k]),
            .evt_o   (ch_evt[k])
        );
    end

    // Dead-time pairs for three phases; both sides low during the gap
    for (genvar p = 0; p < 3; p++) begin : g_ph
        logic [DT_W-1:0] gap_r;            // Remaining dead time
        logic            ref_q_r;          // Last reference level
        logic            hi_r;             // High-side output
        logic            lo_r;             // Low-side output
        wire quiet = dbg_halt_i & doff;
        wire drive = moe & ~quiet & (gap_r == '0);
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                gap_r   <= '0;
                ref_q_r <= 1'b0;
                hi_r    <= 1'b0;
                lo_r    <= 1'b0;
            end else begin
                ref_q_r <= ch_ref[p];
                if (ch_ref[p] != ref_q_r) begin
                    gap_r <= dt_r;
                end else if (gap_r != '0) begin
                    gap_r <= gap_r - 1'b1;
                end
                hi_r <= drive & ref_q_r & (ch_ref[p] == ref_q_r);
                lo_r <= ADVANCED & drive & ~ref_q_r & (ch_ref[p] == ref_q_r);
            end
        end
        assign pwm_o[p]   = hi_r;
        assign pwm_n_o[p] = lo_r;
    end

    // Read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        (addr_i == `PCT_A_CTRL)  ? {21'h0, ctrl_r} :
        (addr_i == `PCT_A_STAT)  ? {26'h0, stat_r} :
        (addr_i == `PCT_A_MASK)  ? {26'h0, mask_r} :
        (addr_i == `PCT_A_DMAEN) ? {26'h0, dma_en_r} :
        (addr_i == `PCT_A_PSC)   ? 32'(psc_r) :
        (addr_i == `PCT_A_ARR)   ? 32'(arr_r) :
        (addr_i == `PCT_A_CNT)   ? 32'(cnt_r) :
        (addr_i == `PCT_A_DT)    ? 32'(dt_r) :
        (addr_i == `PCT_A_CHM)   ? {16'h0, chm_r} :
        (addr_i == 8'h30)        ? 32'(ccr[0]) :
        (addr_i == 8'h34)        ? 32'(ccr[1]) :
        (addr_i == 8'h38)        ? 32'(ccr[2]) :
        (addr_i == 8'h3c)        ? 32'(ccr[3]) : 32'h0;

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_r <= 32'h0;
        end else begin
            rd_data_r <= rd_i ? rd_mux : 32'h0;
        end
    end

    assign rd_data_o = rd_data_r;
    assign ch_o      = ch_ref;
    assign trig_o    = trig_r;
    assign dma_req_o = dma_r;
    assign irq_o     = |(stat_r & mask_r);

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // Wrap sequences leave out cycles where a write or reset overrides
    sequence up_top_s;
        tick && up_now && !center && at_top && !wr_cnt && !slv_rst;
    endsequence
    sequence down_bot_s;
        tick && !up_now && !center && at_bot && !wr_cnt && !slv_rst;
    endsequence

    up_wrap_a: assert property (up_top_s |=> cnt_r == '0 && stat_r[0] && trig_o)
        else $error("up count did not wrap with update");
    down_wrap_a: assert property (down_bot_s |=> cnt_r == $past(arr_r) && stat_r[0])
        else $error("down count did not reload");
    psc_gap_a: assert property (tick && !enc_mode && psc_r != '0 && !wr_psc |=> !tick)
        else $error("prescaler ticked too soon");

    // Debug halt: frozen count and switches off
    debug_freeze_a: assert property (frozen && !wr_cnt |=> $stable(cnt_r))
        else $error("counter moved while frozen");
    debug_off_a: assert property (dbg_halt_i && doff |=> pwm_o == 3'h0 && pwm_n_o == 3'h0)
        else $error("outputs driven during debug halt");
    no_overlap_a: assert property ((pwm_o & pwm_n_o) == 3'h0)
        else $error("both sides of a pair high");

    // A reference change blanks both sides before either rises
    dead_gap_a: assert property ($changed(ch_ref[0]) |=> !pwm_o[0] && !pwm_n_o[0])
        else $error("phase driven inside dead time");

    // Event outputs and sticky flags
    dma_req_a: assert property (upd && dma_en_r[0] |=> dma_req_o[0] ##1 !dma_req_o[0] || upd)
        else $error("update dma request missing");
    flag_sticky_a: assert property (stat_r[0] && !rd_stat |=> stat_r[0])
        else $error("update flag lost without read");
    irq_raise_a: assert property (|(ev & mask_r) && !wr_mask |=> irq_o)
        else $error("masked-in event gave no interrupt");

    // Trigger start and one-pulse both act on the enable bit
    slv_start_a: assert property (slv_go && !wr_ctrl && !(upd && opm) |=> en)
        else $error("trigger start did not enable counter");
    one_pulse_a: assert property (upd && opm && !wr_ctrl |=> !en)
        else $error("one-pulse did not stop counter");
    enc_dir_a: assert property (enc_mode && tick && !enc_up && !at_bot && !wr_cnt && !slv_rst
        |=> cnt_r == $past(cnt_r) - 1'b1)
        else $error("encoder reverse step did not count down");
endmodule

// [tb/pct_sensor_model.sv]
// Far side of the timer: quadrature encoder and hall/capture levels.
// Assumes step requests are one-cycle pulses made on the timer clock.
module pct_sensor_model (
    input  wire logic       clk_i,   // Clock
    input  wire logic       step_i,  // Move encoder one edge
    input  wire logic       rev_i,   // Step backwards
    input  wire logic [1:0] aux_i,   // Levels for lines 2 and 3
    output logic      [3:0] line_o   // Timer input lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_r = 2'h0;         // Gray phase index
    // One gray step per request, so only one line changes at a time
    always @(posedge clk_i) begin
        if (step_i) begin
            ph_r <= rev_i ? ph_r - 2'h1 : ph_r + 2'h1;
        end
    end
    // Index 0..3 gives A,B = 00,10,11,01: A leads when going forward
    assign line_o = {aux_i, ph_r[1], ph_r[1] ^ ph_r[0]};
endmodule

// [tb/testbench.sv]
// Self-checking bench: registers, counting, PWM, debug, link, encoder, hall.
// Assumes the sensor model as far side and the shared register map header.
`include "pct_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;   // Clock
    logic        rst_b_i = 1'b0; // Reset, active low
    logic [7:0]  addr_i = 8'h00; // Register address
    logic [31:0] wr_data_i = 32'h0; // Write data
    logic        wr_i = 1'b0;    // Write strobe
    logic        rd_i = 1'b0;    // Read strobe
    logic        trig_i = 1'b0;  // Link trigger in
    logic        dbg_i = 1'b0;   // Debug halt
    logic        step = 1'b0;    // Encoder step
    logic        rev = 1'b0;     // Encoder direction
    logic [1:0]  aux = 2'h0;     // Hall and capture levels
    wire  [3:0]  ch_i;           // Sensor lines
    wire  [31:0] rd_data_o;      // Read data
    wire  [3:0]  ch_o;           // Channel outputs
    wire  [2:0]  pwm_o;          // High sides
    wire  [2:0]  pwm_n_o;        // Low sides
    wire         trig_o;         // Update pulse
    wire  [5:0]  dma_req_o;      // DMA pulses
    wire         irq_o;          // Interrupt
    int          n_mismatch = 0; // Mismatches
    int          n_compared = 0; // Comparisons
    int          p, a, hi, hd, c, gap;
    logic [31:0] v, w;
    logic        nq = 1'b0;
    always #5 clk_i = ~clk_i;
    pct_sensor_model sen_u (.clk_i(clk_i), .step_i(step), .rev_i(rev), .aux_i(aux),
                            .line_o(ch_i));
    pct_timer dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .ch_i(ch_i), .trig_i(trig_i), .dbg_halt_i(dbg_i), .ch_o(ch_o), .pwm_o(pwm_o),
        .pwm_n_o(pwm_n_o), .trig_o(trig_o), .dma_req_o(dma_req_o), .irq_o(irq_o));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= ad;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rd_data_o;
        @(posedge clk_i);
    endtask
    task automatic enc(input int n, input logic r);
        repeat (n) begin
            @(posedge clk_i);
            step <= 1'b1;
            rev <= r;
            @(posedge clk_i);
            step <= 1'b0;
            cyc(3);
        end
    endtask
    // High cycles of a channel over 180 clocks, ARR 9: period 10, or 18 centered
    function automatic int pwm_exp(input int m, input int cc);
        if (cc == 0) return 0;
        if (cc > 9) return 180;
        return (m == 2) ? 10 * (2 * cc - 1) : 18 * cc;
    endfunction
    task automatic final_report;
        $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // No phase ever has both sides on, and the phase 0 low side waits out the dead time
    always @(posedge clk_i) begin
        if (|(pwm_o & pwm_n_o)) chk("both sides", pwm_o & pwm_n_o, 0);
        if (pwm_n_o[0] & !nq) chk("dead gap", gap > 2, 1);
        gap <= pwm_o[0] ? 0 : gap + 1;
        nq <= pwm_n_o[0];
    end
    // Cuts a hang short; the whole run needs far less
    initial begin
        #400us;
        n_mismatch++;
        final_report();
    end
    initial begin
        v = $urandom(32'hfdc2c490);
        cyc(6);
        chk("outputs in reset", {ch_o, pwm_o, pwm_n_o, trig_o, dma_req_o, irq_o}, 0);
        rst_b_i <= 1'b1;
        rd(`PCT_A_ARR, v);
        chk("arr reset", v, 32'hffff);
        rd(`PCT_A_PSC, v);
        chk("psc reset", v, 0);
        for (int k = 0; k < 6; k++) begin
            w = $urandom;
            wr(`PCT_A_ARR, w);
            wr(8'h28, w);
            rd(`PCT_A_ARR, v);
            chk("arr readback", v, {16'h0, w[15:0]});
            rd(8'h28, v);
            chk("unmapped read", v, 0);
        end
        $display("Test registers done");
        wr(`PCT_A_MASK, 1);
        wr(`PCT_A_DMAEN, 1);
        for (int k = 0; k < 4; k++) begin
            p = $urandom_range(3, 0);
            a = $urandom_range(12, 3);
            wr(`PCT_A_PSC, p);
            wr(`PCT_A_ARR, a);
            wr(`PCT_A_CTRL, k[0] ? 3 : 1);
            cyc(2 * (a + 1) * (p + 1));
            hi = 0;
            hd = 0;
            repeat (4 * (a + 1) * (p + 1)) begin
                @(posedge clk_i);
                #1 hi += (trig_o === 1'b1);
                hd += (dma_req_o[0] === 1'b1);
            end
            chk("update pulses", hi, 4);
            chk("dma pulses", hd, 4);
            chk("irq on update", irq_o, 1);
            wr(`PCT_A_CTRL, 0);
            wr(`PCT_A_CNT, 0);
            rd(`PCT_A_STAT, v);
            chk("update flag", v[0], 1);
            rd(`PCT_A_STAT, v);
            chk("flag cleared", v, 0);
            chk("irq cleared", irq_o, 0);
        end
        $display("Test counting done");
        wr(`PCT_A_PSC, 0);
        wr(`PCT_A_ARR, 9);
        wr(`PCT_A_DT, 2);
        wr(`PCT_A_CHM, 3);
        for (int m = 0; m < 3; m++) begin
            for (int j = 0; j < 3; j++) begin
                c = (j == 0) ? 0 : (j == 1) ? 3 : 10;
                wr(`PCT_A_CTRL, 32'h401 | (m << 1));
                wr(`PCT_A_CCR0, c);
                cyc(40);
                hi = 0;
                repeat (180) begin
                    @(posedge clk_i);
                    #1 hi += (ch_o[0] === 1'b1);
                end
                chk("pwm high count", hi, pwm_exp(m, c));
            end
        end
        $display("Test pwm done");
        wr(`PCT_A_CTRL, 32'h431);
        dbg_i <= 1'b1;
        cyc(6);
        chk("outputs off in halt", {pwm_o, pwm_n_o}, 0);
        rd(`PCT_A_CNT, v);
        cyc(7);
        rd(`PCT_A_CNT, w);
        chk("frozen count", w, v);
        dbg_i <= 1'b0;
        cyc(10);
        chk("full duty after halt", pwm_o[0], 1);
        wr(`PCT_A_CTRL, 32'h81);
        rd(`PCT_A_CNT, v);
        cyc(5);
        rd(`PCT_A_CNT, w);
        chk("gated count", w, v);
        trig_i <= 1'b1;
        cyc(3);
        rd(`PCT_A_CNT, w);
        chk("gate open", w !== v, 1);
        wr(`PCT_A_CTRL, 32'hc8);
        wr(`PCT_A_CNT, 0);
        wr(`PCT_A_ARR, 5);
        trig_i <= 1'b0;
        rd(`PCT_A_STAT, v);
        trig_i <= 1'b1;
        cyc(20);
        rd(`PCT_A_STAT, v);
        chk("start and one-pulse flags", v, 32'h21);
        rd(`PCT_A_CTRL, v);
        chk("one-pulse stop", v, 32'hc8);
        $display("Test debug and link done");
        wr(`PCT_A_CTRL, 0);
        wr(`PCT_A_ARR, 32'hffff);
        wr(`PCT_A_CTRL, 32'h101);
        wr(`PCT_A_CNT, 100);
        enc(8, 1'b0);
        rd(`PCT_A_CNT, v);
        chk("encoder forward", v, 108);
        enc(3, 1'b1);
        rd(`PCT_A_CNT, v);
        chk("encoder back", v, 105);
        wr(`PCT_A_CHM, 1);
        wr(`PCT_A_CTRL, 32'h201);
        rd(`PCT_A_STAT, v);
        aux <= 2'h1;
        cyc(4);
        aux <= 2'h0;
        cyc(5);
        rd(`PCT_A_STAT, v);
        chk("hall capture flag", v[1], 1);
        $display("Test encoder and hall done");
        final_report();
    end
endmodule
